// ---- hw/ddrt_controller.sv ----
// Memory controller end: AHB-Lite command registers and cycle-counted command spacing.
`timescale 1ns/1ps
module ddrt_controller
    import ddrt_pkg::*;
#(
    parameter int XARD_SLOW_BASE_P = XARD_SLOW_BASE // Slow exit read base for the speed bin.
)
(
    input wire logic clk, // System and link clock.
    input wire logic ce, // Clock enable, freezes all state when low.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size, word only.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic hreadyout, // AHB slave ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hresp, // AHB response, always OKAY.
    ddrt_if.ctl link // Command link to the device.
);

    if (XARD_SLOW_BASE_P < 1 || XARD_SLOW_BASE_P > 255)
    begin : g_bad_base
        $error("XARD_SLOW_BASE_P out of range");
    end

    logic dph_reg;
    logic dph_write_reg;
    logic [7:0] dph_addr_reg;
    logic pend_reg;
    ddrt_cmd_e pend_cmd_reg;
    logic [1:0] pend_ba_reg;
    logic [ADDR_W-1:0] pend_addr_reg;
    logic freq_req_reg;
    logic pd_slow_reg;
    logic [2:0] wr_reg;
    logic [2:0] additive_latency_reg;
    ddrt_state_e state_reg;
    logic [7:0] mrd_cnt_reg;
    logic [7:0] xp_cnt_reg;
    logic [7:0] xard_cnt_reg;
    logic [7:0] dal_cnt_reg;
    logic issue;
    logic [7:0] xard_next;
    logic cmd_wr;
    logic low_power;

    function automatic logic [7:0] slow_read_wait(input logic [2:0] lat);
        int v;
        v = XARD_SLOW_BASE_P - int'(lat);
        return (v < 1) ? 8'h1 : 8'(v);
    endfunction

    assign cmd_wr = dph_reg && dph_write_reg && dph_addr_reg == REG_CMD;
    assign low_power = state_reg == ST_SR || state_reg == ST_PPD;

    // Each access takes one wait state so that read data leaves a flip-flop.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dph_reg <= 1'b0;
            dph_write_reg <= 1'b0;
            dph_addr_reg <= 8'h0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            if (!dph_reg && hsel && hready && htrans[1])
            begin
                dph_reg <= 1'b1;
                dph_write_reg <= hwrite;
                dph_addr_reg <= haddr[7:0];
                hreadyout <= 1'b0;
            end
            else if (dph_reg)
            begin
                dph_reg <= 1'b0;
                hreadyout <= 1'b1;
                case (dph_addr_reg)
                    REG_ODT: hrdata <= {30'h0, freq_req_reg, link.odt};
                    REG_STATUS: hrdata <= {24'h0, link.freq_chg, link.dqs_diff, link.term_on,
                                           pd_slow_reg, state_reg, pend_reg};
                    REG_TIMING: hrdata <= {8'h0, PRECHARGE_PERIOD_CYCLES, 5'h0,
                                           additive_latency_reg, 5'h0, wr_reg};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    // A command write while one is still pending is dropped; software polls busy.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pend_reg <= 1'b0;
            pend_cmd_reg <= CMD_NOP;
            pend_ba_reg <= 2'h0;
            pend_addr_reg <= '0;
        end
        else if (ce)
        begin
            if (cmd_wr && !pend_reg)
            begin
                pend_reg <= 1'b1;
                pend_cmd_reg <= ddrt_cmd_e'(hwdata[CMD_CODE_LSB +: 4]);
                pend_ba_reg <= hwdata[CMD_BA_LSB +: 2];
                pend_addr_reg <= hwdata[CMD_ADDR_LSB +: ADDR_W];
            end
            else if (issue)
                pend_reg <= 1'b0;
        end
    end

    // A pending command goes out only once every counter guarding it is zero.
    always_comb
    begin
        case (pend_cmd_reg)
            CMD_MRS: issue = pend_reg && mrd_cnt_reg == 8'h0 && xp_cnt_reg == 8'h0;
            CMD_ACT: issue = pend_reg && xp_cnt_reg == 8'h0 && dal_cnt_reg == 8'h0;
            CMD_RD: issue = pend_reg && xard_cnt_reg == 8'h0 && xp_cnt_reg == 8'h0;
            default: issue = pend_reg && xp_cnt_reg == 8'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            link.cmd <= CMD_NOP;
            link.ba <= 2'h0;
            link.addr <= '0;
        end
        else if (ce)
        begin
            link.cmd <= issue ? pend_cmd_reg : CMD_NOP;
            link.ba <= pend_ba_reg;
            link.addr <= pend_addr_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            link.odt <= 1'b0;
            freq_req_reg <= 1'b0;
        end
        else if (ce && dph_reg && dph_write_reg && dph_addr_reg == REG_ODT)
        begin
            link.odt <= hwdata[ODT_LEVEL_BIT];
            freq_req_reg <= hwdata[ODT_FREQ_BIT];
        end
    end

    // The clock-change permission is withdrawn as soon as the state leaves the low-power set.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            link.freq_chg <= 1'b0;
        else if (ce)
            link.freq_chg <= freq_req_reg && low_power && !(issue && pend_cmd_reg == CMD_SRX)
                && !(issue && pend_cmd_reg == CMD_PDX);
    end

    // Shadow of the programmed mode registers.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pd_slow_reg <= 1'b0;
            wr_reg <= MR_WR_RESET;
            additive_latency_reg <= ADDITIVE_LATENCY_RESET;
        end
        else if (ce && issue && pend_cmd_reg == CMD_MRS)
        begin
            if (pend_ba_reg == BA_MR)
            begin
                pd_slow_reg <= pend_addr_reg[MR_PD_SLOW_BIT];
                wr_reg <= pend_addr_reg[MR_WR_LSB +: 3];
            end
            else if (pend_ba_reg == BA_EMR1)
                additive_latency_reg <= pend_addr_reg[EMR_ADDITIVE_LATENCY_LSB +: 3];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_reg <= ST_IDLE;
        else if (ce && issue)
        begin
            case (pend_cmd_reg)
                CMD_ACT: state_reg <= ST_ACTIVE;
                CMD_WRA: state_reg <= ST_IDLE;
                CMD_PDE: state_reg <= (state_reg == ST_ACTIVE) ? ST_APD : ST_PPD;
                CMD_PDX: state_reg <= (state_reg == ST_APD) ? ST_ACTIVE : ST_IDLE;
                CMD_SRE: state_reg <= ST_SR;
                CMD_SRX: state_reg <= ST_IDLE;
                default: state_reg <= state_reg;
            endcase
        end
    end

    always_comb
    begin
        if (pd_slow_reg)
            xard_next = slow_read_wait(additive_latency_reg) - 8'h1;
        else
            xard_next = 8'(XARD_FAST_CYC - 1);
    end

    // Counters load N-1 as the command leaves, so the next may be taken N edges later.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mrd_cnt_reg <= 8'h0;
            xp_cnt_reg <= 8'h0;
            xard_cnt_reg <= 8'h0;
            dal_cnt_reg <= 8'h0;
        end
        else if (ce)
        begin
            if (issue && pend_cmd_reg == CMD_MRS)
                mrd_cnt_reg <= 8'(MODE_SET_SPACING_CYC - 1);
            else
                mrd_cnt_reg <= sat_dec(mrd_cnt_reg);
            if (issue && pend_cmd_reg == CMD_PDX)
                xp_cnt_reg <= 8'(PD_EXIT_CMD_CYC - 1);
            else
                xp_cnt_reg <= sat_dec(xp_cnt_reg);
            if (issue && pend_cmd_reg == CMD_PDX && state_reg == ST_APD)
                xard_cnt_reg <= xard_next;
            else
                xard_cnt_reg <= sat_dec(xard_cnt_reg);
            if (issue && pend_cmd_reg == CMD_WRA)
                dal_cnt_reg <= 8'({5'h0, wr_reg} + PRECHARGE_PERIOD_CYCLES - 8'h1);
            else
                dal_cnt_reg <= sat_dec(dal_cnt_reg);
        end
    end

endmodule // ddrt_controller

// ---- hw/ddrt_pkg.sv ----
// Shared constants, command codes and cycle arithmetic for the timing-rule link.
package ddrt_pkg;

    typedef enum logic [3:0] {CMD_NOP, CMD_MRS, CMD_ACT, CMD_RD, CMD_WRA, CMD_PDE, CMD_PDX,
                              CMD_SRE, CMD_SRX} ddrt_cmd_e;
    typedef enum logic [2:0] {ST_IDLE, ST_ACTIVE, ST_APD, ST_PPD, ST_SR} ddrt_state_e;

    localparam int ADDR_W = 14;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam int MR_PD_SLOW_BIT = 12;
    localparam int MR_WR_LSB = 9;
    localparam int EMR_DQS_OFF_BIT = 10;
    localparam int EMR_ADDITIVE_LATENCY_LSB = 3;
    localparam logic [2:0] MR_WR_RESET = 3'h1;
    localparam logic [2:0] ADDITIVE_LATENCY_RESET = 3'h0;

    localparam int TERM_ON_CYC = 2;
    localparam int PD_EXIT_CMD_CYC = 2;
    localparam int XARD_FAST_CYC = 2;
    localparam int XARD_SLOW_BASE = 8;
    localparam int MODE_SET_SPACING_CYC = 2;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TRP_PS = 15000;

    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ODT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TIMING = 8'h0c;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_BA_LSB = 4;
    localparam int CMD_ADDR_LSB = 16;
    localparam int ODT_LEVEL_BIT = 0;
    localparam int ODT_FREQ_BIT = 1;

    // Whole cycles that cover a time given in picoseconds.
    function automatic logic [7:0] param_cycle_count(input int t_ps);
        return 8'((t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    endfunction

    localparam logic [7:0] PRECHARGE_PERIOD_CYCLES = param_cycle_count(TRP_PS);

    // Count down to zero and hold there.
    function automatic logic [7:0] sat_dec(input logic [7:0] v);
        return (v == 8'h0) ? 8'h0 : v - 8'h1;
    endfunction

endpackage

// ---- hw/ddrt_if.sv ----
// Command and termination link between the memory controller and the memory device.
`timescale 1ns/1ps
interface ddrt_if;
    ddrt_pkg::ddrt_cmd_e cmd;
    logic [1:0] ba;
    logic [ddrt_pkg::ADDR_W-1:0] addr;
    logic odt;
    logic freq_chg;
    logic term_on;
    logic dqs_diff;

    modport ctl (output cmd, output ba, output addr, output odt, output freq_chg,
                 input term_on, input dqs_diff);
    modport dev (input cmd, input ba, input addr, input odt, input freq_chg,
                 output term_on, output dqs_diff);
endinterface

// ---- hw/ddrt_device.sv ----
// Memory device end: mode registers, termination timing and command spacing checks.
`timescale 1ns/1ps
module ddrt_device
    import ddrt_pkg::*;
(
    input wire logic clk, // Link clock.
    input wire logic ce, // Clock enable, freezes all state when low.
    input wire logic resetn, // Synchronous reset, active low.
    ddrt_if.dev link, // Command link from the controller.
    output ddrt_state_e state_o, // Power and bank state.
    output logic pd_slow_o, // Slow active power-down exit selected.
    output logic act_early_o, // Sticky: activate came too soon.
    output logic mrs_early_o, // Sticky: mode set came too soon.
    output logic freq_bad_o // Sticky: clock change outside self refresh and precharge power-down.
);

    logic [2:0] odt_hist_reg;
    logic [2:0] wr_reg;
    logic [2:0] additive_latency_reg;
    logic [7:0] xp_cnt_reg;
    logic [7:0] mrd_cnt_reg;
    logic [7:0] dal_cnt_reg;

    // The history counts registered levels on actual edges, never elapsed time.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            odt_hist_reg <= 3'h0;
            link.term_on <= 1'b0;
        end
        else if (ce)
        begin
            odt_hist_reg <= {odt_hist_reg[1:0], link.odt};
            // On two edges after the first registered high; off after the
            // third edge, the half-period point past the second trailing edge.
            link.term_on <= odt_hist_reg[TERM_ON_CYC-1] | (odt_hist_reg[2] & link.term_on);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pd_slow_o <= 1'b0;
            wr_reg <= MR_WR_RESET;
            additive_latency_reg <= ADDITIVE_LATENCY_RESET;
            link.dqs_diff <= 1'b1;
        end
        else if (ce && link.cmd == CMD_MRS)
        begin
            if (link.ba == BA_MR)
            begin
                pd_slow_o <= link.addr[MR_PD_SLOW_BIT];
                wr_reg <= link.addr[MR_WR_LSB +: 3];
            end
            else if (link.ba == BA_EMR1)
            begin
                link.dqs_diff <= ~link.addr[EMR_DQS_OFF_BIT];
                additive_latency_reg <= link.addr[EMR_ADDITIVE_LATENCY_LSB +: 3];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_o <= ST_IDLE;
        else if (ce)
        begin
            case (link.cmd)
                CMD_ACT: state_o <= ST_ACTIVE;
                // Write data postamble length is never checked; a long one only
                // costs bus turnaround time.
                CMD_WRA: state_o <= ST_IDLE;
                CMD_PDE: state_o <= (state_o == ST_ACTIVE) ? ST_APD : ST_PPD;
                CMD_PDX: state_o <= (state_o == ST_APD) ? ST_ACTIVE : ST_IDLE;
                CMD_SRE: state_o <= ST_SR;
                CMD_SRX: state_o <= ST_IDLE;
                default: state_o <= state_o;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            xp_cnt_reg <= 8'h0;
            mrd_cnt_reg <= 8'h0;
            dal_cnt_reg <= 8'h0;
        end
        else if (ce)
        begin
            xp_cnt_reg <= (link.cmd == CMD_PDX) ? 8'(PD_EXIT_CMD_CYC - 1) : sat_dec(xp_cnt_reg);
            mrd_cnt_reg <= (link.cmd == CMD_MRS) ? 8'(MODE_SET_SPACING_CYC - 1)
                : sat_dec(mrd_cnt_reg);
            dal_cnt_reg <= (link.cmd == CMD_WRA)
                ? 8'({5'h0, wr_reg} + PRECHARGE_PERIOD_CYCLES - 8'h1) : sat_dec(dal_cnt_reg);
        end
    end

    // Violation flags are sticky until reset; nothing clears them otherwise.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            act_early_o <= 1'b0;
            mrs_early_o <= 1'b0;
            freq_bad_o <= 1'b0;
        end
        else if (ce)
        begin
            if (link.cmd == CMD_ACT && (xp_cnt_reg != 8'h0 || dal_cnt_reg != 8'h0))
                act_early_o <= 1'b1;
            if (link.cmd == CMD_MRS && mrd_cnt_reg != 8'h0)
                mrs_early_o <= 1'b1;
            // A clock change is tolerated in self refresh and precharge power-down.
            if (link.freq_chg && state_o != ST_SR && state_o != ST_PPD)
                freq_bad_o <= 1'b1;
        end
    end

endmodule // ddrt_device

// ---- sim/ddrt_sva.sv ----
// Checker for termination timing, mode copies and command spacing on the link.
`timescale 1ns/1ps
module ddrt_sva
    import ddrt_pkg::*;
#(
    parameter int XARD_SLOW_BASE_P = XARD_SLOW_BASE // Slow exit read base.
)
(
    input wire logic clk, // Link clock.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic [3:0] cmd, // Command pulse.
    input wire logic [1:0] ba, // Mode register select.
    input wire logic [ADDR_W-1:0] addr, // Mode value.
    input wire logic odt, // Termination control.
    input wire logic freq_chg, // Clock change announced.
    input wire logic term_on, // Termination applied.
    input wire logic dqs_diff // Strobe differential.
);
    logic [2:0] wr_reg;
    logic [2:0] additive_latency_reg;
    logic slow_reg;
    logic lp_reg;
    logic [7:0] wra_cnt_reg;
    logic [7:0] rd_cnt_reg;
    int slow_n;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // A slow exit never waits under one cycle, even with a large additive latency.
    assign slow_n = (XARD_SLOW_BASE_P - int'(additive_latency_reg) > 1)
        ? XARD_SLOW_BASE_P - int'(additive_latency_reg) : 1;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_reg <= MR_WR_RESET;
            slow_reg <= 1'b0;
            additive_latency_reg <= ADDITIVE_LATENCY_RESET;
        end
        else if (cmd == CMD_MRS && ba == BA_MR)
        begin
            wr_reg <= addr[MR_WR_LSB+:3];
            slow_reg <= addr[MR_PD_SLOW_BIT];
        end
        else if (cmd == CMD_MRS && ba == BA_EMR1)
            additive_latency_reg <= addr[EMR_ADDITIVE_LATENCY_LSB+:3];
    end

    // Conservative: active power-down also counts, so only a change outside all
    // low-power states is caught.
    always_ff @(posedge clk)
    begin
        if (!resetn || cmd == CMD_SRX || cmd == CMD_PDX)
            lp_reg <= 1'b0;
        else if (cmd == CMD_SRE || cmd == CMD_PDE)
            lp_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wra_cnt_reg <= 8'h0;
            rd_cnt_reg <= 8'h0;
        end
        else
        begin
            wra_cnt_reg <= (cmd == CMD_WRA) ? 8'(wr_reg) + PRECHARGE_PERIOD_CYCLES - 8'h1
                : (wra_cnt_reg == 8'h0) ? 8'h0 : wra_cnt_reg - 8'h1;
            rd_cnt_reg <= (cmd == CMD_PDX) ? (slow_reg ? 8'(slow_n - 1) : 8'(XARD_FAST_CYC - 1))
                : (rd_cnt_reg == 8'h0) ? 8'h0 : rd_cnt_reg - 8'h1;
        end
    end

    AST_TERM_ON: assert property ($rose(odt) && !term_on ##1 odt [*2] |-> !term_on ##1 term_on)
        else $error("termination on timing wrong");
    AST_TERM_OFF: assert property ($fell(odt) && term_on ##1 !odt [*3] |-> term_on ##1 !term_on)
        else $error("termination off timing wrong");
    AST_DQS_MODE: assert property (cmd == CMD_MRS && ba == BA_EMR1 |=> dqs_diff == !$past(addr[EMR_DQS_OFF_BIT]))
        else $error("strobe mode not following mode bit");
    AST_MRS_SPACING: assert property (cmd == CMD_MRS |=> cmd != CMD_MRS)
        else $error("mode sets too close");
    AST_PDX_SPACING: assert property (cmd == CMD_PDX |=> cmd == CMD_NOP)
        else $error("command right after exit");
    AST_WRA_ACT: assert property (cmd == CMD_ACT |-> wra_cnt_reg == 8'h0)
        else $error("activate inside write recovery");
    AST_XARD_READ: assert property (cmd == CMD_RD |-> rd_cnt_reg == 8'h0)
        else $error("read too soon after exit");
    AST_FREQ_LP: assert property (freq_chg |-> lp_reg)
        else $error("clock change outside low power");
endmodule // ddrt_sva

// ---- sim/ddrt_tb.sv ----
// Bench: controller and device joined over the link, driven over AHB-Lite.
`timescale 1ns/1ps
module ddrt_tb;
    import ddrt_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    ddrt_state_e state;
    logic pd_slow;
    logic act_early;
    logic mrs_early;
    logic freq_bad;
    int fail_count = 0;
    int check_count = 0;
    logic [63:0] notes[$];
    logic [63:0] note;
    logic rd_dp = 1'b0;
    logic [31:0] rd;
    logic [2:0] wr;
    logic [2:0] additive_latency;
    ddrt_cmd_e lp_in[2] = '{CMD_PDE, CMD_SRE};
    ddrt_cmd_e lp_out[2] = '{CMD_PDX, CMD_SRX};
    ddrt_state_e lp_st[2] = '{ST_PPD, ST_SR};

    ddrt_if link();
    ddrt_controller #(.XARD_SLOW_BASE_P(XARD_SLOW_BASE)) i_ddrt_controller (.clk(clk),
        .ce(1'b1), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .link(link.ctl));
    ddrt_device i_ddrt_device (.clk(clk), .ce(1'b1), .resetn(resetn), .link(link.dev),
        .state_o(state), .pd_slow_o(pd_slow), .act_early_o(act_early),
        .mrs_early_o(mrs_early), .freq_bad_o(freq_bad));
    ddrt_sva #(.XARD_SLOW_BASE_P(XARD_SLOW_BASE)) i_ddrt_sva (.clk(clk), .resetn(resetn),
        .cmd(link.cmd), .ba(link.ba), .addr(link.addr), .odt(link.odt),
        .freq_chg(link.freq_chg), .term_on(link.term_on), .dqs_diff(link.dqs_diff));

    always #4 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        check_count++;
        if ((got & m) !== (exp & m))
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Read results are checked here, in issue order; a zero mask marks a poll.
    always @(posedge clk)
    begin
        if (rd_dp && hreadyout)
        begin
            rd_dp = 1'b0;
            note = notes.pop_front();
            if (note[63:32] != 32'h0)
                chk(hrdata, note[31:0], note[63:32]);
        end
        if (htrans == 2'h2 && hreadyout && !hwrite)
            rd_dp = 1'b1;
    end

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m);
        if (!w)
            notes.push_back({m, e});
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (!hreadyout);
        rd = hrdata;
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, 32'h0, 32'h0);
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        ahb(1'b0, a, 32'h0, e, m);
    endtask

    // Commands sent while busy are dropped, so wait for idle on both sides.
    task automatic issue(input ddrt_cmd_e c, input logic [1:0] b, input logic [13:0] v);
        rd = 32'h1;
        while (rd[0])
            get(REG_STATUS, 32'h0, 32'h0);
        put(REG_CMD, {2'h0, v, 10'h0, b, c});
        rd = 32'h1;
        while (rd[0])
            get(REG_STATUS, 32'h0, 32'h0);
    endtask

    initial
    begin
        rd = $urandom(32'h82a48d3d);
        wr = 3'(4 + $urandom % 4);
        additive_latency = 3'($urandom % 4);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        get(REG_TIMING, {8'h0, 8'((TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS), 16'h1},
            32'h00ff_0707);
        get(REG_STATUS, 32'h40, 32'hff);
        put(8'h10, 32'hffff_ffff);
        get(8'h10, 32'h0, 32'hffff_ffff);
        issue(CMD_MRS, BA_EMR1, {3'h0, 1'b1, 4'h0, additive_latency, 3'h0});
        get(REG_STATUS, 32'h0, 32'h40);
        issue(CMD_MRS, BA_EMR1, {7'h0, additive_latency, 3'h0});
        get(REG_STATUS, 32'h40, 32'h40);
        for (int i = 0; i < 2; i++)
        begin
            issue(lp_in[i], 2'h0, 14'h0);
            put(REG_ODT, 32'h2);
            get(REG_STATUS, {24'h0, 1'b1, 3'h0, lp_st[i], 1'b0}, 32'h8e);
            chk({29'h0, state}, {29'h0, lp_st[i]}, 32'h7);
            issue(lp_out[i], 2'h0, 14'h0);
            put(REG_ODT, 32'h0);
            get(REG_STATUS, 32'h0, 32'h8e);
        end
        issue(CMD_ACT, 2'h0, 14'h0);
        for (int i = 0; i < 2; i++)
        begin
            issue(CMD_MRS, BA_MR, {1'b0, ~i[0], wr, 9'h0});
            get(REG_TIMING, {21'h0, additive_latency, 5'h0, wr}, 32'h0707);
            get(REG_STATUS, {27'h0, ~i[0], 3'h1, 1'b0}, 32'h1e);
            issue(CMD_PDE, 2'h0, 14'h0);
            get(REG_STATUS, 32'h4, 32'he);
            chk({28'h0, pd_slow, state}, {28'h0, ~i[0], ST_APD}, 32'hf);
            issue(CMD_PDX, 2'h0, 14'h0);
            issue(CMD_RD, 2'h0, 14'h0);
        end
        put(REG_ODT, 32'h1);
        get(REG_ODT, 32'h1, 32'h3);
        get(REG_STATUS, 32'h20, 32'h20);
        put(REG_ODT, 32'h0);
        get(REG_ODT, 32'h0, 32'h3);
        get(REG_STATUS, 32'h0, 32'h20);
        issue(CMD_WRA, 2'h0, 14'h0);
        issue(CMD_ACT, 2'h0, 14'h0);
        get(REG_STATUS, 32'h2, 32'he);
        @(posedge clk);
        chk({29'h0, act_early, mrs_early, freq_bad}, 32'h0, 32'h7);
        tally_and_finish();
    end

    // The sequence needs well under a thousand cycles; five thousand means a hang.
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule // ddrt_tb
